//--- src/pfci_top.sv
// PLL fabric control interface: reference select, reset, lock and outputs
// Notes on behaviour
// - Active reference chosen from four inputs by two-bit select, changeable live.
// - Each reference may come from a pad or the core clock tree.
// - Reset low holds PLL in reset; release enables it.
// - Lock flag rises on lock, falls when loss of lock seen.
// - Stopped reference leaves lock flag at its previous value.
// - Internal feedback closes loop inside, no phase relation guaranteed.
// - Local feedback closes loop locally and phase-aligns output to reference.
// - Core feedback uses a routed output clock; aligns and cancels tree delay.
// - Reference may be sourced from a named core clock.
// - Post-divider is 1, 2, 4 or 8; at least 2 with multiple outputs.
// - Three outputs, each enabled separately, each divider 1 to 256; here control bit 7 is forced to zero, so output 2 is never enabled.
// - Phase shift only for divider 2, 4 or 6 at listed angles.
// - Output clocks are offered to the global clock network.
// - Internal mode output equals ref times M over N, O and C; here only C divides the reference.
`default_nettype none
module pfci_top
   import pfci_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic nrst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Reference clocks, pad or core sourced, with their select, loop reset and feedback clock
   input wire logic [3:0] ref_clock_inputs,
   input wire logic [1:0] ref_source_select,
   input wire logic pll_reset_n,
   input wire logic fabric_feedback_clock,
   // Outputs to the global clock network, lock flag and interrupt
   output logic pll_output_clock_0,
   output logic pll_output_clock_1,
   output logic pll_output_clock_2,
   output logic pll_locked,
   output logic irq
);
   // Register file and bus answer
   logic [31:0] ctrl_q, ctrl_d;
   logic [7:0] mult_q, mult_d;
   logic [15:0] div_q [3], div_d [3];
   logic [2:0] ists_q, ists_d;
   logic [2:0] ien_q, ien_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic [31:0] stat_word;
   // Loop state, reference sampling and lock
   pfci_state_t st_q, st_d;
   logic [2:0] rcnt_q, rcnt_d;
   logic ref_sel, ref_q1, ref_q2, ref_q3, ref_edge;
   logic fb_q1, fb_q2;
   logic lock_prev_q;
   logic [1:0] sel_q;
   logic sel_jump, loop_ok;
   logic loop_run, cfg_ok, locked;
   // Decoded settings and legality terms
   logic [1:0] sel_eff, fb_mode;
   logic [2:0] out_en;
   logic [1:0] post_code;
   logic [2:0] phase_ok;
   logic post_ok, fb_ok;
   logic [2:0] clk_vec;
   logic wr, rd;

   // Decoded controls
   assign out_en = ctrl_q[PFCI_CTRL_EN_LO +: 3];
   assign fb_mode = ctrl_q[PFCI_CTRL_FB_LO +: 2];
   assign post_code = ctrl_q[PFCI_CTRL_POST_LO +: 2];
   // Status word: one-hot loop state, config legality, effective select, lock flag.
   // Built live, so a select taken from the pins reads back without a write first
   assign stat_word = {25'h0, st_q, cfg_ok, sel_eff, locked};

   // reference select
   // Pin select wins unless software forces a source
   assign sel_eff = ctrl_q[PFCI_CTRL_RUN_BIT] ? ctrl_q[PFCI_CTRL_SEL_LO +: 2] :
      ref_source_select;
   assign ref_sel = ref_clock_inputs[sel_eff];

   // Reference sampled through two flops before edge detection
   // A reference must run below half of clk, or its edges are lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ref_q1 <= 1'b0;
         ref_q2 <= 1'b0;
         ref_q3 <= 1'b0;
         fb_q1 <= 1'b0;
         fb_q2 <= 1'b0;
      end else begin
         ref_q1 <= ref_sel;
         ref_q2 <= ref_q1;
         ref_q3 <= ref_q2;
         fb_q1 <= fabric_feedback_clock;
         fb_q2 <= fb_q1;
      end
   end
   // Rising edge of the synchronised reference advances the lock count
   assign ref_edge = ref_q2 & ~ref_q3;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         case (div_q[i][PFCI_DIV_PH_LO +: 3])
            3'h0: phase_ok[i] = 1'b1;
            3'h1, 3'h3: phase_ok[i] = div_q[i][7:0] == 8'h03;
            3'h2: phase_ok[i] = div_q[i][7:0] == 8'h01 || div_q[i][7:0] == 8'h03 ||
               div_q[i][7:0] == 8'h05;
            3'h4, 3'h6: phase_ok[i] = div_q[i][7:0] == 8'h01;
            default: phase_ok[i] = 1'b0;
         endcase
      end
   end

   // post-divider legality
   // Post-divide one only drives a single output; two or more need at least two
   always_comb begin
      post_ok = post_code != 2'h0 || out_en == 3'h0 || out_en == 3'h1 || out_en == 3'h2 ||
         out_en == 3'h4;
      // core feedback needs an active loop clock
      fb_ok = (fb_mode != 2'(PFCI_FB_CORE) || fb_q2 || out_en != 3'h0) && fb_mode != 2'h3;
      // A zero multiplier would stall the loop, so it counts as illegal
      cfg_ok = &phase_ok && post_ok && fb_ok && mult_q != 8'h00;
   end

   // reset hold
   // Loop state: hold at least the minimum reset, then acquire
   always_comb begin
      st_d = st_q;
      rcnt_d = rcnt_q;
      case (st_q)
         PFCI_ST_RESET: begin
            if (!pll_reset_n) rcnt_d = 3'h0;
            else if (rcnt_q >= 3'(PFCI_RST_CYC)) st_d = PFCI_ST_ACQ;
            else rcnt_d = 3'(rcnt_q + 3'h1);
         end
         PFCI_ST_ACQ: begin
            if (!pll_reset_n) st_d = PFCI_ST_RESET;
            else if (locked) st_d = PFCI_ST_LOCK;
         end
         PFCI_ST_LOCK: begin
            if (!pll_reset_n) st_d = PFCI_ST_RESET;
            else if (!locked) st_d = PFCI_ST_ACQ;
         end
         default: st_d = PFCI_ST_RESET;
      endcase
      // Loop reset overrides every state, so even a short pulse lands
      if (!pll_reset_n) st_d = PFCI_ST_RESET;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= PFCI_ST_RESET;
         rcnt_q <= 3'h0;
      end else begin
         st_q <= st_d;
         rcnt_q <= rcnt_d;
      end
   end
   // Outputs and the lock detector stop the moment the loop reset pin falls
   assign loop_run = st_q != PFCI_ST_RESET && pll_reset_n;

   // loss of lock
   // A live jump of the effective reference, like an illegal setting, clears the lock here; the
   // detector restarts on the new source instead of counting edges of two clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) sel_q <= 2'h0;
      else sel_q <= sel_eff;
   end
   assign sel_jump = sel_q != sel_eff;
   assign loop_ok = cfg_ok && !sel_jump;

   pfci_lockdet u_lock (
      .clk(clk),
      .nrst(nrst),
      .loop_run(loop_run),
      .ref_edge(ref_edge),
      .cfg_ok(loop_ok),
      .locked(locked)
   );
   // Lock flag comes straight from the detector's flop
   assign pll_locked = locked;

   // internal loop, local alignment: all channels share the reference
   // frequency chain
   // Behavioural model: output derived from the reference by C, M and N not modelled
   // Disabled channels and a held loop drive a steady low
   for (genvar g = 0; g < 3; g++) begin : g_out
      pfci_outdiv u_div (
         .clk_in(ref_sel),
         .rst_n(loop_run),
         .enable(out_en[g] & loop_run),
         .div_m1(div_q[g][7:0]),
         .phase_sel(div_q[g][PFCI_DIV_PH_LO +: 3]),
         .clk_out(clk_vec[g])
      );
   end
   assign pll_output_clock_0 = clk_vec[0];
   assign pll_output_clock_1 = clk_vec[1];
   assign pll_output_clock_2 = clk_vec[2];

   // Wishbone: answer one cycle after the request, drop after one cycle
   // The ack cycle itself is never taken as a second request
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

   // Register writes and sticky interrupts
   always_comb begin
      ctrl_d = ctrl_q;
      mult_d = mult_q;
      div_d = div_q;
      ien_d = ien_q;
      ists_d = ists_q;
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      rdat_d = rdat_q;
      if (wr) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               case (wb_adr_i)
                  PFCI_CTRL_OFS: ctrl_d[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                  PFCI_MULT_OFS: if (b == 0) mult_d = wb_dat_i[7:0];
                  PFCI_DIV0_OFS: if (b < 2) div_d[0][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                  PFCI_DIV1_OFS: if (b < 2) div_d[1][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                  PFCI_DIV2_OFS: if (b < 2) div_d[2][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                  PFCI_ICLR_OFS: if (b == 0) ists_d = ists_q & ~wb_dat_i[2:0];
                  PFCI_IEN_OFS: if (b == 0) ien_d = wb_dat_i[2:0];
                  default: ;
               endcase
            end
         end
      end
      // Reserved control bits always read back as zero
      ctrl_d[31:10] = 22'h0;
      ctrl_d[7] = 1'b0;
      // Events set after the clear, so a same-cycle event survives
      if (locked && !lock_prev_q) ists_d[PFCI_IRQ_LOCK] = 1'b1;
      // Unlock needs a lock seen first, so reset alone flags nothing
      if (!locked && lock_prev_q) ists_d[PFCI_IRQ_UNLOCK] = 1'b1;
      if (loop_run && !cfg_ok) ists_d[PFCI_IRQ_CFGERR] = 1'b1;
      // Read data is captured with the request and shown with ack
      if (rd) begin
         case (wb_adr_i)
            PFCI_CTRL_OFS: rdat_d = ctrl_q;
            PFCI_MULT_OFS: rdat_d = {24'h0, mult_q};
            PFCI_DIV0_OFS: rdat_d = {16'h0, div_q[0]};
            PFCI_DIV1_OFS: rdat_d = {16'h0, div_q[1]};
            PFCI_DIV2_OFS: rdat_d = {16'h0, div_q[2]};
            PFCI_STAT_OFS: rdat_d = stat_word;
            PFCI_ISTS_OFS: rdat_d = {29'h0, ists_q};
            PFCI_IEN_OFS: rdat_d = {29'h0, ien_q};
            // Write-only and unmapped places read as zero
            default: rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // Register file, bus answer and lock edge tracking
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= PFCI_CTRL_RST;
         mult_q <= PFCI_MULT_RST;
         for (int i = 0; i < 3; i++) div_q[i] <= PFCI_DIV_RST;
         ien_q <= 3'h0;
         ists_q <= 3'h0;
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
         lock_prev_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         mult_q <= mult_d;
         div_q <= div_d;
         ien_q <= ien_d;
         ists_q <= ists_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         lock_prev_q <= locked;
      end
   end

   // Registered answer and data; data holds until the next read
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   // Level interrupt while any enabled status bit is set
   assign irq = |(ists_q & ien_q);
endmodule
`default_nettype wire

//--- pkg/pfci_pkg.sv
// Package of constants and types for the PLL fabric control interface
`default_nettype none
package pfci_pkg;
   // Register byte offsets
   localparam logic [7:0] PFCI_CTRL_OFS = 8'h00;
   localparam logic [7:0] PFCI_MULT_OFS = 8'h04;
   localparam logic [7:0] PFCI_DIV0_OFS = 8'h08;
   localparam logic [7:0] PFCI_DIV1_OFS = 8'h0c;
   localparam logic [7:0] PFCI_DIV2_OFS = 8'h10;
   localparam logic [7:0] PFCI_STAT_OFS = 8'h14;
   localparam logic [7:0] PFCI_ISTS_OFS = 8'h18;
   localparam logic [7:0] PFCI_ICLR_OFS = 8'h1c;
   localparam logic [7:0] PFCI_IEN_OFS = 8'h20;
   // Control field positions
   localparam int PFCI_CTRL_RUN_BIT = 0;
   localparam int PFCI_CTRL_SEL_LO = 1;
   localparam int PFCI_CTRL_FB_LO = 3;
   localparam int PFCI_CTRL_EN_LO = 5;
   localparam int PFCI_CTRL_POST_LO = 8;
   // Divider register fields
   localparam int PFCI_DIV_PH_LO = 8;
   // Interrupt status bits
   localparam int PFCI_IRQ_LOCK = 0;
   localparam int PFCI_IRQ_UNLOCK = 1;
   localparam int PFCI_IRQ_CFGERR = 2;
   // Reset values
   localparam logic [31:0] PFCI_CTRL_RST = 32'h0000_0020;
   localparam logic [7:0] PFCI_MULT_RST = 8'h01;
   localparam logic [3:0] PFCI_PRE_RST = 4'h1;
   localparam logic [15:0] PFCI_DIV_RST = 16'h0000;
   // Time the PLL is held in reset, and lock settling
   localparam int PFCI_CLK_MHZ = 50;
   localparam int PFCI_RST_MIN_NS = 10;
   localparam int PFCI_RST_CYC = (PFCI_RST_MIN_NS * PFCI_CLK_MHZ + 999) / 1000 < 1 ? 1 :
      (PFCI_RST_MIN_NS * PFCI_CLK_MHZ + 999) / 1000;
   localparam int PFCI_LOCK_CYC = 64;
   localparam int PFCI_STALL_CYC = 8;
   // Feedback modes
   typedef enum logic [1:0] {
      PFCI_FB_INTERNAL = 2'h0,
      PFCI_FB_LOCAL = 2'h1,
      PFCI_FB_CORE = 2'h2
   } pfci_fb_t;
   // Loop state
   typedef enum logic [2:0] {
      PFCI_ST_RESET = 3'h1,
      PFCI_ST_ACQ = 3'h2,
      PFCI_ST_LOCK = 3'h4
   } pfci_state_t;
endpackage
`default_nettype wire

//--- src/pfci_outdiv.sv
// One output divider channel with phase-shift taps
`default_nettype none
module pfci_outdiv
   import pfci_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n,
   // Settings
   input wire logic enable,
   input wire logic [7:0] div_m1,
   input wire logic [2:0] phase_sel,
   // Output
   output logic clk_out
);
   logic [7:0] cnt_q, cnt_d;
   logic [7:0] half;
   logic [7:0] shift;
   logic [7:0] pos;

   // Phase as counter offset: units of 45 degrees over 8 ticks
   always_comb begin
      half = 8'((9'(div_m1) + 9'h1) >> 1);
      shift = 8'((9'(div_m1) + 9'h1) * 9'(phase_sel) >> 3);
      pos = cnt_q + shift;
      if (pos > div_m1) pos = 8'(pos - div_m1 - 8'h1);
   end

   // Free-running divider, restarts on loop reset
   always_comb begin
      cnt_d = (cnt_q >= div_m1) ? 8'h00 : 8'(cnt_q + 8'h1);
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) cnt_q <= 8'h00;
      else cnt_q <= cnt_d;
   end

   // Divide by one passes the source clock straight through
   assign clk_out = !enable ? 1'b0 : (div_m1 == 8'h00) ? clk_in : (pos < half);
endmodule
`default_nettype wire

//--- src/pfci_lockdet.sv
// Lock detector counting reference activity against the loop clock
`default_nettype none
module pfci_lockdet
   import pfci_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Loop status
   input wire logic loop_run,
   input wire logic ref_edge,
   input wire logic cfg_ok,
   // Result
   output logic locked
);
   logic [7:0] good_q, good_d;
   logic [7:0] idle_q, idle_d;
   logic locked_q, locked_d;
   logic stalled;

   // A stopped reference freezes the flag instead of dropping it
   always_comb begin
      stalled = idle_q >= 8'(PFCI_STALL_CYC);
      idle_d = ref_edge ? 8'h00 : (stalled ? idle_q : 8'(idle_q + 8'h1));
      good_d = good_q;
      locked_d = locked_q;
      if (!loop_run || !cfg_ok) begin
         good_d = 8'h00;
         locked_d = 1'b0;
      end else if (!stalled) begin
         if (good_q >= 8'(PFCI_LOCK_CYC)) locked_d = 1'b1;
         else if (ref_edge) good_d = 8'(good_q + 8'h1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         good_q <= 8'h00;
         idle_q <= 8'h00;
         locked_q <= 1'b0;
      end else begin
         good_q <= good_d;
         idle_q <= idle_d;
         locked_q <= locked_d;
      end
   end

   assign locked = locked_q;
endmodule
`default_nettype wire

//--- tb/pfci_fabric_model.sv
// Fabric-side model: reference clock sources and feedback routing
`default_nettype none
module pfci_fabric_model (
   // Control from the bench, and output clock zero from the block
   input wire logic stop,
   input wire logic out_clk,
   // Toward the block
   output logic [3:0] ref_clk,
   output logic fb_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_q [4] = '{default: 1'b0};
   // four references with periods of six or eight clk cycles: slow enough to be
   // sampled, fast enough never to look stalled; toggles stay off the rising clk edge
   for (genvar i = 0; i < 4; i++) begin : g_ref
      // A stopped reference freezes where it is, like a dead pad
      always #(80 - 20 * (i % 2)) if (!stop) ref_q[i] = ~ref_q[i];
      assign ref_clk[i] = ref_q[i];
   end
   // output zero routed back as core feedback
   assign fb_clk = out_clk;
endmodule
`default_nettype wire

//--- tb/pfci_assertions.sv
// Checker on the PLL control block ports
`default_nettype none
module pfci_assertions (
   // System
   input wire logic clk,
   input wire logic nrst,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Loop
   input wire logic [3:0] ref_clock_inputs,
   input wire logic pll_reset_n,
   input wire logic pll_locked
);
   logic [8:0] hi_q, hi_d;
   logic [3:0] still_q, still_d, ref_q;
   // Cycles out of loop reset, and cycles with every reference idle
   always_comb begin
      hi_d = pll_reset_n ? hi_q + {8'h00, ~&hi_q} : 9'h000;
      still_d = (ref_clock_inputs != ref_q) ? 4'h0 : still_q + {3'h0, ~&still_q};
   end
   // Saturating, so a long run never wraps back under the limits
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hi_q <= 9'h000;
         still_q <= 4'h0;
         ref_q <= 4'h0;
      end else begin
         hi_q <= hi_d;
         still_q <= still_d;
         ref_q <= ref_clock_inputs;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Bus answer timing
   a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("stray ack");
   a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
      |=> $stable(wb_dat_o)) else $error("read data moved");
   // Lock behaviour around loop reset and reference activity
   a_lock_rst: assert property ((!pll_reset_n) [*4] |-> !pll_locked)
      else $error("lock in reset");
   a_lock_wait: assert property ($rose(pll_reset_n) |=> !pll_locked [*8])
      else $error("early lock");
   a_lock_slow: assert property ($rose(pll_locked) |-> hi_q >= 9'h0c8)
      else $error("lock too soon");
   a_lock_freeze: assert property ((still_q >= 4'hc && pll_reset_n && $past(pll_reset_n)
      && !(wb_cyc_i && wb_we_i)) |-> $stable(pll_locked)) else $error("lock moved");
endmodule
bind pfci_top pfci_assertions u_pfci_assertions (.clk, .nrst, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_dat_o, .wb_ack_o, .ref_clock_inputs, .pll_reset_n, .pll_locked);
`default_nettype wire

//--- tb/tb_top.sv
// Bench for the PLL control block: bus tasks and scenario sequence
`default_nettype none
module tb_top
   import pfci_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [1:0] ref_source_select = 2'h0;
   logic pll_reset_n = 1'b0;
   logic stop = 1'b0;
   logic [31:0] wb_dat_o;
   logic [3:0] ref_clock_inputs;
   logic wb_ack_o, fabric_feedback_clock, pll_locked, irq;
   logic pll_output_clock_0, pll_output_clock_1, pll_output_clock_2;
   int num_errors = 0;
   int compares = 0;
   // Divider settings: {legal, phase step, divide minus one}
   logic [11:0] tbl [11] = '{12'h8ff, 12'h101, 12'he01, 12'h403, 12'hb03, 12'h202,
      12'h105, 12'ha05, 12'h503, 12'h703, 12'ha01};
   always #10 clk = ~clk;
   pfci_top u_pfci_top (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_clock_inputs, .ref_source_select, .pll_reset_n,
      .fabric_feedback_clock, .pll_output_clock_0, .pll_output_clock_1,
      .pll_output_clock_2, .pll_locked, .irq);
   pfci_fabric_model u_pfci_fabric_model (.stop, .out_clk(pll_output_clock_0),
      .ref_clk(ref_clock_inputs), .fb_clk(fabric_feedback_clock));
   task automatic wrap_up;
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // One classic cycle; entered just after a clock edge, held until ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         num_errors++;
         wrap_up();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask
   // Bounded wait for a level; running out ends the run
   task automatic waitv(ref logic s, input logic v);
      for (int n = 0; n < 3000 && s !== v; n++) begin
         @(posedge clk);
      end
      if (s !== v) begin
         num_errors++;
         wrap_up();
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      // Reset values; unmapped place reads zero and ignores writes
      rd(PFCI_CTRL_OFS, PFCI_CTRL_RST);
      rd(PFCI_ISTS_OFS, 32'h0);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0);
      // First lock; event latched while masked, then enabled and cleared
      pll_reset_n <= 1'b1;
      waitv(pll_locked, 1'b1);
      chkb(irq, 1'b0);
      rd(PFCI_ISTS_OFS, 32'h1);
      wr(PFCI_IEN_OFS, 32'h1);
      chkb(irq, 1'b1);
      wr(PFCI_ICLR_OFS, 32'h1);
      chkb(irq, 1'b0);
      rd(PFCI_ISTS_OFS, 32'h0);
      // Stopped references must not move the lock flag
      stop <= 1'b1;
      repeat (100) @(posedge clk);
      chkb(pll_locked, 1'b1);
      stop <= 1'b0;
      // select changed only inside a five-cycle loop reset
      pll_reset_n <= 1'b0;
      @(posedge clk);
      ref_source_select <= 2'h2;
      repeat (4) @(posedge clk);
      chkb(pll_locked, 1'b0);
      pll_reset_n <= 1'b1;
      rd(PFCI_STAT_OFS, 32'h4, 32'h6);
      rd(PFCI_ISTS_OFS, 32'h2, 32'h2);
      waitv(pll_locked, 1'b1);
      // Eleven phase and divider pairs, legal or refused
      // 225 and 315 degrees are refused: the destination inverts 45 or 135 itself
      for (int i = 0; i < 11; i++) begin
         wr(PFCI_DIV0_OFS, {21'h0, tbl[i][10:0]});
         rd(PFCI_STAT_OFS, {28'h0, tbl[i][11], 3'h0}, 32'h8);
      end
      rd(PFCI_ISTS_OFS, 32'h4, 32'h4);
      // Two outputs refuse post-divide one; core feedback then relocks
      wr(PFCI_CTRL_OFS, 32'h0000_0060);
      rd(PFCI_STAT_OFS, 32'h0, 32'h8);
      wr(PFCI_CTRL_OFS, 32'h0000_0170);
      rd(PFCI_STAT_OFS, 32'h8, 32'h8);
      waitv(pll_locked, 1'b1);
      waitv(pll_output_clock_1, 1'b1);
      waitv(pll_output_clock_1, 1'b0);
      chkb(pll_output_clock_2, 1'b0);
      waitv(pll_output_clock_0, 1'b1);
      waitv(pll_output_clock_0, 1'b0);
      // Software override jumps the reference live: lock is lost at once
      wr(PFCI_CTRL_OFS, 32'h0000_0171);
      chkb(pll_locked, 1'b0);
      rd(PFCI_STAT_OFS, 32'h0, 32'h7);
      wrap_up();
   end
endmodule
`default_nettype wire
